/* hdl/alarm_interrupt_and_clock_monitor.sv */
// Purpose: Alarm status flags, interrupt gating, clock monitor, alarmed VC queue
// Assumes: All inputs synchronous to aclk; event inputs are one-cycle pulses
// Notes:   Read side effects act at AR handshake
//
// Notes on behaviour
// - Upper input parity: word mode 15:0, byte mode 15:8.
// - Lower input parity: byte mode only, bits 7:0.
// - Input parity flags clear on read; sense from config.
// - Five SRAM lane parity flags, flag 4 is 39:32, flag 0 is 7:0.
// - SRAM parity flags clear on read.
// - Search error above 40 branches.
// - Search error above 63 copies when limit enabled.
// - Failed lookups to host when enabled; search error clears on read.
// - First enables gate first status onto interrupt; reset 0.
// - Second enables 9..1 gate second status onto interrupt.
// - First enable bit 10 shows valid flag; read clears nothing.
// - Valid flag high until queue drained.
// - Clock activity bits set on rises, clear on read.
// - Bit 2 input clock, bit 1 output clock, bit 0 system clock.
// - Enabled alarms push their 16-bit VC index.
// - Queue holds seven; each read returns the next.
// - Overflow replaces the oldest entry.
// - Index equals the external RAM low address of the record.
// - First status read clears all but summary and valid bits.
// - Queue entry written with the alarm flag.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`default_nettype none

module alarm_interrupt_and_clock_monitor #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned IDX_W  = 16
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [15:0]        input_cell_data_bus,
  input  wire logic [1:0]         input_parity_bits,
  input  wire logic               input_word_valid,
  input  wire logic [39:0]        sram_data_bus,
  input  wire logic [4:0]         sram_parity_bits,
  input  wire logic               sram_data_valid,
  input  wire logic               search_done,
  input  wire logic [5:0]         search_branch_count,
  input  wire logic               search_failed,
  input  wire logic               multicast_done,
  input  wire logic [6:0]         multicast_copy_count,
  input  wire logic               start_of_cell_error,
  input  wire logic [14:0]        first_status_events,
  input  wire logic [4:0]         alarm_events,
  input  wire logic [IDX_W-1:0]   alarm_vc_index,
  input  wire logic               input_interface_clock,
  input  wire logic               output_interface_clock,
  input  wire logic               system_clock,
  output logic                    interrupt_request_n,
  output logic                    route_failed_to_host
);

  // ==========================================================================
  // Functions
  function automatic logic parity_bad(input logic x, input logic p, input logic even);
    parity_bad = x ^ p ^ ~even;
  endfunction

  function automatic logic [2:0] q_inc(input logic [2:0] ptr);
    q_inc = (ptr == 3'(alarm_irq_pkg::Q_DEPTH - 1)) ? 3'd0 : ptr + 3'd1;
  endfunction

  function automatic logic [15:0] strb_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s, input logic [15:0] m);
    strb_merge = ({s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]} & m) | (old & ~m);
  endfunction

  // ==========================================================================
  // State
  logic [15:0]      stat1_reg, stat1_next;
  logic [15:0]      stat2_reg, stat2_next;
  logic [15:0]      en1_reg, en1_next;
  logic [15:0]      en2_reg, en2_next;
  logic [15:0]      incfg_reg, incfg_next;
  logic [15:0]      mcfg_reg, mcfg_next;
  logic [2:0]       clkact_reg, clkact_next;
  logic [2:0]       clkprev_reg, clkprev_next;
  logic [IDX_W-1:0] q_mem_reg [alarm_irq_pkg::Q_DEPTH];
  logic [IDX_W-1:0] q_mem_next [alarm_irq_pkg::Q_DEPTH];
  logic [2:0]       q_wr_reg, q_wr_next;
  logic [2:0]       q_rd_reg, q_rd_next;
  logic [2:0]       q_cnt_reg, q_cnt_next;
  logic             irq_n_reg, irq_n_next;
  logic             tohost_reg, tohost_next;

  logic             awready_reg, awready_next;
  logic             wready_reg, wready_next;
  logic             bvalid_reg, bvalid_next;
  logic [1:0]       bresp_reg, bresp_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic [31:0]      wdata_reg, wdata_next;
  logic [3:0]       wstrb_reg, wstrb_next;
  logic             arready_reg, arready_next;
  logic             rvalid_reg, rvalid_next;
  logic [1:0]       rresp_reg, rresp_next;
  logic [31:0]      rdata_reg, rdata_next;

  // ==========================================================================
  // Combinational next state
  logic [5:0]  widx;
  logic [5:0]  ridx;
  logic        do_write;
  logic        do_read;
  logic [15:0] s1_set;
  logic [15:0] s2_set;
  logic [2:0]  clk_now;
  logic        push;
  logic        pop;
  logic        srch_err;
  logic        even_in;
  logic        even_sram;
  logic [15:0] rval;
  logic        rhit;

  always_comb begin
    widx       = waddr_reg[7:2];
    ridx       = s_axi_araddr[7:2];
    do_write   = !awready_reg && !wready_reg && !bvalid_reg;
    do_read    = s_axi_arvalid && arready_reg;
    even_in    = incfg_reg[alarm_irq_pkg::INCFG_SENSE_BIT];
    even_sram  = mcfg_reg[alarm_irq_pkg::MC_SSENSE_BIT];

    // Second status event sources
    s2_set = 16'h0000;
    s2_set[alarm_irq_pkg::S2_SOC_BIT] = start_of_cell_error;
    if (input_word_valid) begin
      if (incfg_reg[alarm_irq_pkg::INCFG_BYTE_BIT]) begin
        s2_set[alarm_irq_pkg::S2_IPAR_LSB+1] =
          parity_bad(^input_cell_data_bus[15:8], input_parity_bits[1], even_in);
        s2_set[alarm_irq_pkg::S2_IPAR_LSB] =
          parity_bad(^input_cell_data_bus[7:0], input_parity_bits[0], even_in);
      end else begin
        s2_set[alarm_irq_pkg::S2_IPAR_LSB+1] =
          parity_bad(^input_cell_data_bus, input_parity_bits[1], even_in);
      end
    end
    if (sram_data_valid) begin
      for (int i = 0; i < 5; i++) begin
        s2_set[alarm_irq_pkg::S2_SPAR_LSB+i] =
          parity_bad(^sram_data_bus[8*i +: 8], sram_parity_bits[i], even_sram);
      end
    end
    srch_err = (search_done && (search_branch_count > alarm_irq_pkg::SEARCH_MAX_BR))
             || (multicast_done && mcfg_reg[alarm_irq_pkg::MC_LIMIT_BIT]
                 && (multicast_copy_count > alarm_irq_pkg::MCAST_MAX));
    s2_set[alarm_irq_pkg::S2_SRCH_BIT] = srch_err;

    // First status event sources
    s1_set = {1'b0, first_status_events} & alarm_irq_pkg::STAT1_EVT_MASK;
    s1_set[alarm_irq_pkg::S1_ALARM_LSB +: 5] =
      s1_set[alarm_irq_pkg::S1_ALARM_LSB +: 5] | alarm_events;

    // Status registers: set wins over read clear
    stat2_next = stat2_reg;
    if (do_read && ridx == alarm_irq_pkg::IDX_STATUS2) begin
      stat2_next = 16'h0000;
    end
    stat2_next = stat2_next | s2_set;

    stat1_next = stat1_reg;
    if (do_read && ridx == alarm_irq_pkg::IDX_STATUS1) begin
      stat1_next = 16'h0000;
    end
    stat1_next = stat1_next | s1_set;

    tohost_next = search_done && search_failed && mcfg_reg[alarm_irq_pkg::MC_TOHOST_BIT];

    // Clock activity monitor
    clk_now      = {input_interface_clock, output_interface_clock, system_clock};
    clkprev_next = clk_now;
    clkact_next  = clkact_reg;
    if (do_read && ridx == alarm_irq_pkg::IDX_CLKMON) begin
      clkact_next = 3'b000;
    end
    clkact_next = clkact_next | (clk_now & ~clkprev_reg);

    // Alarmed connection queue
    push = |(alarm_events & mcfg_reg[alarm_irq_pkg::MC_QEN_LSB +: 5]);
    pop  = do_read && ridx == alarm_irq_pkg::IDX_ALARMQ && q_cnt_reg != 3'd0;
    q_mem_next = q_mem_reg;
    q_wr_next  = q_wr_reg;
    q_rd_next  = q_rd_reg;
    q_cnt_next = q_cnt_reg;
    if (pop) begin
      q_rd_next  = q_inc(q_rd_reg);
      q_cnt_next = q_cnt_reg - 3'd1;
    end
    if (push) begin
      q_mem_next[q_wr_reg] = alarm_vc_index;
      q_wr_next = q_inc(q_wr_reg);
      if (q_cnt_reg == 3'(alarm_irq_pkg::Q_DEPTH) && !pop) begin
        q_rd_next = q_inc(q_rd_reg);
      end else begin
        q_cnt_next = q_cnt_next + 3'd1;
      end
    end

    // Live bits read through
    rhit = 1'b1;
    case (ridx)
      alarm_irq_pkg::IDX_STATUS1: begin
        rval = stat1_reg;
        rval[alarm_irq_pkg::S1_VALID_BIT]   = (q_cnt_reg != 3'd0);
        rval[alarm_irq_pkg::S1_SUMMARY_BIT] = |stat2_reg;
      end
      alarm_irq_pkg::IDX_STATUS2:   rval = stat2_reg;
      alarm_irq_pkg::IDX_ENABLE1: begin
        rval = en1_reg;
        rval[alarm_irq_pkg::S1_VALID_BIT] = (q_cnt_reg != 3'd0);
      end
      alarm_irq_pkg::IDX_ENABLE2:   rval = en2_reg;
      alarm_irq_pkg::IDX_CLKMON:    rval = {13'h0000, clkact_reg};
      alarm_irq_pkg::IDX_ALARMQ:
        rval = (q_cnt_reg != 3'd0) ? q_mem_reg[q_rd_reg] : 16'h0000;
      alarm_irq_pkg::IDX_INCFG:     rval = incfg_reg;
      alarm_irq_pkg::IDX_MASTERCFG: rval = mcfg_reg;
      default: begin
        rval = 16'h0000;
        rhit = 1'b0;
      end
    endcase

    // Read channel
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (do_read) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rdata_next   = {16'h0000, rval};
      rresp_next   = rhit ? alarm_irq_pkg::RESP_OKAY : alarm_irq_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end

    // Write channel
    awready_next = awready_reg;
    wready_next  = wready_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    if (s_axi_awvalid && awready_reg) begin
      awready_next = 1'b0;
      waddr_next   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      wready_next = 1'b0;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    en1_next   = en1_reg;
    en2_next   = en2_reg;
    incfg_next = incfg_reg;
    mcfg_next  = mcfg_reg;
    if (do_write) begin
      bvalid_next = 1'b1;
      bresp_next  = alarm_irq_pkg::RESP_OKAY;
      case (widx)
        alarm_irq_pkg::IDX_ENABLE1:
          en1_next = strb_merge(en1_reg, wdata_reg, wstrb_reg, alarm_irq_pkg::EN1_WR_MASK);
        alarm_irq_pkg::IDX_ENABLE2:
          en2_next = strb_merge(en2_reg, wdata_reg, wstrb_reg, alarm_irq_pkg::EN2_WR_MASK);
        alarm_irq_pkg::IDX_INCFG:
          incfg_next = strb_merge(incfg_reg, wdata_reg, wstrb_reg, 16'hffff);
        alarm_irq_pkg::IDX_MASTERCFG:
          mcfg_next = strb_merge(mcfg_reg, wdata_reg, wstrb_reg, alarm_irq_pkg::MC_WR_MASK);
        alarm_irq_pkg::IDX_STATUS1, alarm_irq_pkg::IDX_STATUS2,
        alarm_irq_pkg::IDX_CLKMON, alarm_irq_pkg::IDX_ALARMQ: begin
        end
        default: bresp_next = alarm_irq_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end

    // Interrupt request
    irq_n_next = !((|(stat1_reg & en1_reg))
                 || (|(stat2_reg & en2_reg)));
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat1_reg   <= 16'h0000;
      stat2_reg   <= 16'h0000;
      en1_reg     <= alarm_irq_pkg::EN_RESET;
      en2_reg     <= alarm_irq_pkg::EN_RESET;
      incfg_reg   <= alarm_irq_pkg::INCFG_RESET;
      mcfg_reg    <= alarm_irq_pkg::MC_RESET;
      clkact_reg  <= 3'b000;
      clkprev_reg <= 3'b000;
      q_mem_reg   <= '{default: '0};
      q_wr_reg    <= 3'd0;
      q_rd_reg    <= 3'd0;
      q_cnt_reg   <= 3'd0;
      irq_n_reg   <= 1'b1;
      tohost_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= alarm_irq_pkg::RESP_OKAY;
      waddr_reg   <= '0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= alarm_irq_pkg::RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end else begin
      stat1_reg   <= stat1_next;
      stat2_reg   <= stat2_next;
      en1_reg     <= en1_next;
      en2_reg     <= en2_next;
      incfg_reg   <= incfg_next;
      mcfg_reg    <= mcfg_next;
      clkact_reg  <= clkact_next;
      clkprev_reg <= clkprev_next;
      q_mem_reg   <= q_mem_next;
      q_wr_reg    <= q_wr_next;
      q_rd_reg    <= q_rd_next;
      q_cnt_reg   <= q_cnt_next;
      irq_n_reg   <= irq_n_next;
      tohost_reg  <= tohost_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign s_axi_awready        = awready_reg;
  assign s_axi_wready         = wready_reg;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = arready_reg;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rresp          = rresp_reg;
  assign s_axi_rdata          = rdata_reg;
  assign interrupt_request_n  = irq_n_reg;
  assign route_failed_to_host = tohost_reg;

endmodule

`default_nettype wire

/* hdl/alarm_irq_pkg.sv */
// Purpose: Shared constants for the alarm, interrupt and clock monitor block
// Assumes: 32-bit AXI4-Lite bus, 16-bit registers in the low half of each word
// Notes:   Byte address is four times the register index
`default_nettype none

package alarm_irq_pkg;

  // ==========================================================================
  // Register indices
  localparam int unsigned REG_W          = 16;
  localparam logic [5:0]  IDX_STATUS1    = 6'h02;
  localparam logic [5:0]  IDX_STATUS2    = 6'h03;
  localparam logic [5:0]  IDX_ENABLE1    = 6'h04;
  localparam logic [5:0]  IDX_ENABLE2    = 6'h05;
  localparam logic [5:0]  IDX_CLKMON     = 6'h06;
  localparam logic [5:0]  IDX_ALARMQ     = 6'h07;
  localparam logic [5:0]  IDX_INCFG      = 6'h08;
  localparam logic [5:0]  IDX_MASTERCFG  = 6'h0c;

  // ==========================================================================
  // Field positions
  localparam int unsigned S1_VALID_BIT   = 10;
  localparam int unsigned S1_SUMMARY_BIT = 15;
  localparam int unsigned S1_ALARM_LSB   = 3;
  localparam int unsigned S2_SOC_BIT     = 1;
  localparam int unsigned S2_IPAR_LSB    = 2;
  localparam int unsigned S2_SPAR_LSB    = 4;
  localparam int unsigned S2_SRCH_BIT    = 9;
  localparam int unsigned INCFG_BYTE_BIT = 5;
  localparam int unsigned INCFG_SENSE_BIT = 4;
  localparam int unsigned MC_QEN_LSB     = 0;
  localparam int unsigned MC_LIMIT_BIT   = 5;
  localparam int unsigned MC_TOHOST_BIT  = 6;
  localparam int unsigned MC_SSENSE_BIT  = 7;

  // ==========================================================================
  // Masks and reset values
  localparam logic [15:0] STAT1_EVT_MASK = 16'h7bff;
  localparam logic [15:0] STAT2_EVT_MASK = 16'h03fe;
  localparam logic [15:0] EN1_WR_MASK    = 16'h7bff;
  localparam logic [15:0] EN2_WR_MASK    = 16'h03fe;
  localparam logic [15:0] MC_WR_MASK     = 16'h00ff;
  localparam logic [15:0] EN_RESET       = 16'h0000;
  localparam logic [15:0] INCFG_RESET    = 16'h8002;
  localparam logic [15:0] MC_RESET       = 16'h0000;

  // ==========================================================================
  // Limits and bus answers
  localparam int unsigned Q_DEPTH        = 7;
  localparam logic [5:0]  SEARCH_MAX_BR  = 6'd40;
  localparam logic [6:0]  MCAST_MAX      = 7'd63;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

endpackage

`default_nettype wire

/* tb/alarm_irq_monitor.sv */
// Purpose: Port checks for the alarm, interrupt and clock monitor block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to the top module after endmodule
`default_nettype none
module alarm_irq_monitor #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              search_done,
  input wire logic              search_failed,
  input wire logic              system_clock,
  input wire logic              interrupt_request_n,
  input wire logic              route_failed_to_host
);
  // ====
  // Read index and flag for a system clock rise since the last clock monitor read
  logic [5:0] rd_idx_reg;
  logic       prev_reg;
  logic       armed_reg;
  wire        ar_hs  = s_axi_arvalid && s_axi_arready;
  wire        clk_rd = ar_hs && s_axi_araddr[7:2] == alarm_irq_pkg::IDX_CLKMON;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_idx_reg <= 6'h00;
      prev_reg   <= 1'h0;
      armed_reg  <= 1'h0;
    end else begin
      prev_reg <= system_clock;
      if (ar_hs) begin
        rd_idx_reg <= s_axi_araddr[7:2];
      end
      if (system_clock && !prev_reg) begin
        armed_reg <= 1'h1;
      end else if (clk_rd) begin
        armed_reg <= 1'h0;
      end
    end
  end
  // ====
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence clk_read_after_rise;
    clk_rd && armed_reg;
  endsequence
  irq_reset_a: assert property ($rose(aresetn) |-> interrupt_request_n)
    else $error("interrupt low after reset");
  route_cause_a: assert property (route_failed_to_host |-> $past(search_done && search_failed))
    else $error("host routing without failed search");
  read_answer_a: assert property (ar_hs |=> s_axi_rvalid)
    else $error("no read answer");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  clk_field_a: assert property (s_axi_rvalid && rd_idx_reg == 6'h06 |-> s_axi_rdata[15:3] == 13'h0)
    else $error("clock monitor spare bits set");
  stat2_field_a: assert property (s_axi_rvalid && rd_idx_reg == 6'h03 |-> s_axi_rdata[15:10] == 6'h0 && !s_axi_rdata[0])
    else $error("second status spare bits set");
  sys_activity_a: assert property (clk_read_after_rise |=> s_axi_rvalid && s_axi_rdata[0])
    else $error("system clock activity missed");
endmodule
bind alarm_interrupt_and_clock_monitor alarm_irq_monitor #(.ADDR_W(ADDR_W)) u_alarm_irq_monitor (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .search_done, .search_failed, .system_clock,
  .interrupt_request_n, .route_failed_to_host);
`default_nettype wire

/* tb/host_irq_model.sv */
// Purpose: Host side of the interrupt line, watches service deadline
// Assumes: queue_read marks a taken read of the alarmed queue
// Notes:   Deadline is 3.8 us at 4 ns per cycle
`default_nettype none
module host_irq_model #(
  parameter int DEADLINE = 950
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic interrupt_request_n,
  input wire logic queue_read,
  output logic     late
);
  int cnt = 0;
  always_ff @(posedge aclk) begin
    if (!aresetn) late <= 1'h0;
    else if (cnt > DEADLINE) late <= 1'h1;
    if (!aresetn || interrupt_request_n || queue_read) cnt <= 0;
    else cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the alarm, interrupt and clock monitor
// Assumes: AXI4-Lite master tasks, xorshift stimulus
// Notes:   Inputs change by non-blocking assignment after rising edges
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'heb36d36a;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, late;
  logic [1:0]  s_axi_bresp, s_axi_rresp, input_parity_bits = 2'h0;
  logic [15:0] input_cell_data_bus = 16'h0, alarm_vc_index = 16'h0, q[$];
  logic [39:0] sram_data_bus = 40'h0;
  logic [4:0]  sram_parity_bits = 5'h0, alarm_events = 5'h0;
  logic        input_word_valid = 1'h0, sram_data_valid = 1'h0, search_done = 1'h0;
  logic        search_failed = 1'h0, multicast_done = 1'h0, start_of_cell_error = 1'h0;
  logic [5:0]  search_branch_count = 6'h0;
  logic [6:0]  multicast_copy_count = 7'h0;
  logic [14:0] first_status_events = 15'h0;
  logic        input_interface_clock = 1'h0, output_interface_clock = 1'h0;
  logic        system_clock = 1'h0, interrupt_request_n, route_failed_to_host;
  int          fail_count = 0, checked = 0;
  always #2 aclk = ~aclk;
  alarm_interrupt_and_clock_monitor u_alarm_interrupt_and_clock_monitor (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .input_cell_data_bus, .input_parity_bits, .input_word_valid, .sram_data_bus,
    .sram_parity_bits, .sram_data_valid, .search_done, .search_branch_count,
    .search_failed, .multicast_done, .multicast_copy_count, .start_of_cell_error,
    .first_status_events, .alarm_events, .alarm_vc_index, .input_interface_clock,
    .output_interface_clock, .system_clock, .interrupt_request_n, .route_failed_to_host);
  host_irq_model u_host_irq_model (.aclk, .aresetn, .interrupt_request_n, .late,
    .queue_read(s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h07));
  // ====
  // Helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] s2_exp(input logic bm, ps, ss, lim);
    logic [15:0] e;
    e = {6'h0, search_branch_count > 6'd40 || (lim && multicast_copy_count > 7'd63), 9'h0};
    e[1] = start_of_cell_error;
    if (bm) e[2] = ^{input_cell_data_bus[7:0], input_parity_bits[0]} ^ ~ps;
    if (bm) e[3] = ^{input_cell_data_bus[15:8], input_parity_bits[1]} ^ ~ps;
    else e[3] = ^{input_cell_data_bus, input_parity_bits[1]} ^ ~ps;
    for (int i = 0; i < 5; i++) e[4+i] = ^{sram_data_bus[8*i+:8], sram_parity_bits[i]} ^ ~ss;
    return e;
  endfunction
  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ====
  // Bus master
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    logic a, w, b;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {16'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      {a, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 40) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [5:0] i, output logic [15:0] d, output logic [1:0] r);
    logic a, v;
    int n;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      {a, v, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata[15:0], s_axi_rresp};
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'h0;
      if (v) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 40) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic rc(input logic [5:0] i, input logic [15:0] exp);
    logic [15:0] d;
    logic [1:0]  r;
    rd(i, d, r);
    chk($sformatf("reg %h", i), d, exp);
  endtask
  task automatic tog(input logic [2:0] m);
    @(posedge aclk);
    {input_interface_clock, output_interface_clock, system_clock} <= m;
    @(posedge aclk);
    {input_interface_clock, output_interface_clock, system_clock} <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask
  // ====
  // Scenarios
  initial begin
    logic [31:0] x;
    logic [15:0] d, e;
    logic [1:0]  r;
    logic [4:0]  ae, ev;
    logic        bm, ps, ss, lim;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    for (int k = 2; k < 9; k++) rc(6'(k), (k == 8) ? 16'h8002 : 16'h0);
    wr(6'h04, 16'hffff);
    rc(6'h04, 16'h7bff);
    wr(6'h05, 16'hffff);
    rc(6'h05, 16'h03fe);
    for (int k = 0; k < 12; k++) begin
      x = rnd();
      {lim, ss, ps, bm} = x[3:0];
      wr(6'h08, {10'h200, bm, ps, 4'h2});
      wr(6'h0c, {8'h0, ss, x[4], lim, 5'h0});
      @(posedge aclk);
      x = rnd();
      {input_parity_bits, input_cell_data_bus} <= x[17:0];
      search_branch_count <= 6'd38 + 6'(x[20:18] % 5);
      multicast_copy_count <= 7'd61 + 7'(x[23:21] % 5);
      {start_of_cell_error, search_failed, sram_parity_bits} <= x[31:25];
      sram_data_bus <= {x[7:0], rnd()};
      {input_word_valid, sram_data_valid, search_done, multicast_done} <= 4'hf;
      @(posedge aclk);
      e = s2_exp(bm, ps, ss, lim);
      {input_word_valid, sram_data_valid, search_done, multicast_done} <= 4'h0;
      start_of_cell_error <= 1'h0;
      repeat (3) @(posedge aclk);
      chk("irq", interrupt_request_n, e == 16'h0);
      rc(6'h03, e);
      rc(6'h03, 16'h0);
      chk("irq", interrupt_request_n, 1'h1);
    end
    wr(6'h04, 16'h4000);
    @(posedge aclk);
    first_status_events <= rnd() | 15'h4000;
    start_of_cell_error <= 1'h1;
    @(posedge aclk);
    e = {1'h1, first_status_events & 15'h7bff};
    first_status_events <= 15'h0;
    start_of_cell_error <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("irq", interrupt_request_n, 1'h0);
    rc(6'h02, e);
    rc(6'h02, 16'h8000);
    rc(6'h03, 16'h0002);
    rc(6'h02, 16'h0000);
    chk("irq", interrupt_request_n, 1'h1);
    wr(6'h0c, 16'h001e);
    wr(6'h04, 16'h00f8);
    ae = 5'h0;
    for (int k = 0; k < 10; k++) begin
      @(posedge aclk);
      x = rnd();
      ev = (k == 0) ? 5'h01 : 5'h02 << x[17:16];
      ae = ae | ev;
      alarm_events <= ev;
      alarm_vc_index <= x[15:0];
      if (k > 0) q.push_back(x[15:0]);
      if (q.size() > 7) q.pop_front();
    end
    @(posedge aclk);
    alarm_events <= 5'h0;
    repeat (3) @(posedge aclk);
    chk("irq", interrupt_request_n, 1'h0);
    rc(6'h04, 16'h04f8);
    rc(6'h02, {5'h0, 1'h1, 2'h0, ae, 3'h0});
    rc(6'h04, 16'h04f8);
    while (q.size() > 0) rc(6'h07, q.pop_front());
    rc(6'h04, 16'h00f8);
    rc(6'h07, 16'h0);
    chk("late", late, 1'h0);
    wr(6'h06, 16'hffff);
    rc(6'h06, 16'h0);
    tog(3'h7);
    rc(6'h06, 16'h0007);
    rc(6'h06, 16'h0);
    for (int k = 0; k < 3; k++) begin
      tog(3'h1 << k);
      rc(6'h06, 16'h1 << k);
    end
    rd(6'h3f, d, r);
    chk("rresp", r, 2'h2);
    chk("rdata", d, 16'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
